// [verilog/txb_pkg.sv]
// Purpose: Shared constants and carriers for the transmit buffer and
//          lookup block.
// Assumes: 16-bit external SRAM, word addressed, 17 address bits.
// Notes:   All APB offsets are byte addresses of aligned 32-bit words.
//
// Contract
// - Suppress bit 15 set: build no cells
// - Suppressed queues still get scheduled service times
// - Eight line buffers, 128 frames, 0x800 apart
// - E1: eight multiframes of 16 frames, 32 bytes
// - T1: 128 frames, 32-byte frames, 32-frame multiframes
// - Line bytes written in arrival order
// - E1 with T1 signalling uses T1 layout
// - Two bytes per word, 16 words per frame
// - Upper byte odd channel, lower byte even
// - E1 offset line*2048+mf*256+frame*16+chan/2
// - T1 offset uses mf*512, same split
// - Divide: 6-bit credits, 5-bit channels, 8-bit quotient
// - Modulo add: 120 for T1 structured, else 128
// - Modulo add address: 7-bit frame, 6-bit increment
// - Multiply: 6-bit frame with 5-bit channel count
// - T1 and E1 eighth-multiframe division lookups
// - One table image serves E1 and T1

package txb_pkg;

   // ---------------------------------------------------------------
   // APB register map
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CONFIG = 12'h000;
   localparam logic [11:0] ADDR_BUILT_CNT = 12'h004;
   localparam logic [11:0] ADDR_SKIP_CNT = 12'h008;
   localparam logic [11:0] ADDR_LINE_MODE = 12'h020;
   localparam logic [11:0] ADDR_SUPPRESS = 12'h400;
   localparam int CFG_HS_BIT = 0;
   localparam int MODE_T1_BIT = 0;
   localparam int MODE_STRUCT_BIT = 1;
   localparam int MODE_E1T1SIG_BIT = 12;
   localparam int SUPPRESS_BIT = 15;
   localparam logic [15:0] LINE_MODE_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;

   // ---------------------------------------------------------------
   // SRAM map, word addresses
   // ---------------------------------------------------------------
   localparam logic [16:0] TX_BUF_BASE = 17'h04000;
   localparam logic [16:0] MATH_BASE = 17'h0C000;
   localparam int LINE_SHIFT = 11;
   localparam int E1_MF_SHIFT = 8;
   localparam int T1_MF_SHIFT = 9;
   localparam int FRAME_SHIFT = 4;

   // ---------------------------------------------------------------
   // Lookup operations and result fields in the table word
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_DIV = 3'h0,
      OP_MOD_ADD = 3'h1,
      OP_MULT = 3'h2,
      OP_T1_MF_DIV = 3'h3,
      OP_E1_MF_DIV = 3'h4
   } txb_op_t;
   localparam int DIV_LSB = 0;
   localparam int MULT_LSB = 8;
   localparam int MOD128_LSB = 0;
   localparam int MOD120_LSB = 8;
   localparam int T1_MF_LSB = 0;
   localparam int E1_MF_LSB = 8;

   typedef struct packed {
      logic valid;
      logic we;
      logic [1:0] be;
      logic [16:0] addr;
      logic [15:0] wdata;
   } txb_sram_req_t;

   typedef struct packed {
      logic valid;
      logic [2:0] line;
      logic [2:0] mf;
      logic [4:0] frame;
      logic [4:0] chan;
      logic [7:0] data;
   } txb_byte_t;

   typedef struct packed {
      logic valid;
      txb_op_t op;
      logic [2:0] line;
      logic [6:0] arg_a;
      logic [5:0] arg_b;
   } txb_lk_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] word;
      logic [7:0] result;
   } txb_lk_rsp_t;

   typedef struct packed {
      logic valid;
      logic [7:0] queue;
   } txb_sched_t;

endpackage

// [verilog/txb_top.sv]
// Purpose: Transmit frame buffer writer, math table lookups and
//          per-queue cell build inhibit, with an APB register file.
// Assumes: SRAM read data is valid one cycle after a read request.
// Notes:   Byte writes own the SRAM port; lookups use idle cycles.
`timescale 1ns/1ps

module txb_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire txb_pkg::txb_sched_t sched_in,
   output logic service_tick,
   output txb_pkg::txb_sched_t build_out,
   input wire txb_pkg::txb_byte_t byte_in,
   input wire txb_pkg::txb_lk_req_t lk_req,
   output logic lk_ready,
   output txb_pkg::txb_lk_rsp_t lk_rsp,
   output txb_pkg::txb_sram_req_t sram_req,
   input wire logic [15:0] sram_rdata
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_PEND = 2'b01,
      LK_SENT = 2'b11,
      LK_WAIT = 2'b10
   } txb_lk_state_t;

   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic hs_mode_r;
   logic [15:0] line_mode_r [8];
   logic [255:0] suppress_r;
   logic [15:0] built_cnt_r;
   logic [15:0] skip_cnt_r;
   logic service_tick_r;
   txb_pkg::txb_sched_t build_r;
   txb_pkg::txb_sram_req_t sram_r;
   txb_pkg::txb_sram_req_t sram_nxt;
   txb_lk_state_t lk_state_r;
   txb_pkg::txb_lk_req_t lk_hold_r;
   logic lk_ready_r;
   txb_pkg::txb_lk_rsp_t lk_rsp_r;
   logic [7:0] lk_result;
   logic [12:0] lk_operand;

   logic apb_setup;
   logic apb_wr;
   logic [31:0] rd_val;
   logic rd_err;
   logic sel_mode;
   logic sel_supp;
   logic [2:0] apb_line;
   logic [7:0] apb_queue;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign service_tick = service_tick_r;
   assign build_out = build_r;
   assign sram_req = sram_r;
   assign lk_ready = lk_ready_r;
   assign lk_rsp = lk_rsp_r;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   // One wait-free access: pready rises in the first access cycle.
   assign apb_setup = psel & ~penable & ~pready_r;
   assign apb_wr = psel & penable & pready_r & pwrite;
   assign sel_mode = (paddr[11:5] == txb_pkg::ADDR_LINE_MODE[11:5]);
   assign sel_supp = (paddr[11:10] == txb_pkg::ADDR_SUPPRESS[11:10]);
   assign apb_line = paddr[4:2];
   assign apb_queue = paddr[9:2];

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         rd_err = 1'b1;
      end else if (paddr == txb_pkg::ADDR_CONFIG) begin
         rd_val[txb_pkg::CFG_HS_BIT] = hs_mode_r;
      end else if (paddr == txb_pkg::ADDR_BUILT_CNT) begin
         rd_val[15:0] = built_cnt_r;
      end else if (paddr == txb_pkg::ADDR_SKIP_CNT) begin
         rd_val[15:0] = skip_cnt_r;
      end else if (sel_mode) begin
         rd_val[15:0] = line_mode_r[apb_line];
      end else if (sel_supp) begin
         rd_val[txb_pkg::SUPPRESS_BIT] = suppress_r[apb_queue];
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apb_setup;
         if (apb_setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_r <= rd_err;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_mode_r <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            line_mode_r[i] <= txb_pkg::LINE_MODE_RST;
         end
      end else if (apb_wr) begin
         if (paddr == txb_pkg::ADDR_CONFIG) begin
            hs_mode_r <= pwdata[txb_pkg::CFG_HS_BIT];
         end
         if (sel_mode && paddr[1:0] == 2'b00) begin
            line_mode_r[apb_line] <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         suppress_r <= '0;
      end else if (apb_wr && sel_supp && paddr[1:0] == 2'b00) begin
         suppress_r[apb_queue] <= pwdata[txb_pkg::SUPPRESS_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Scheduler side: service always advances, build may be inhibited
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         service_tick_r <= 1'b0;
         build_r <= '0;
      end else begin
         service_tick_r <= sched_in.valid;
         build_r.queue <= sched_in.queue;
         build_r.valid <= sched_in.valid &
                          ~suppress_r[sched_in.queue];
      end
   end

   // Counters roll over; software clears neither, so no set/clear race.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         built_cnt_r <= txb_pkg::CNT_RST;
         skip_cnt_r <= txb_pkg::CNT_RST;
      end else if (sched_in.valid) begin
         if (suppress_r[sched_in.queue]) begin
            skip_cnt_r <= skip_cnt_r + 16'h0001;
         end else begin
            built_cnt_r <= built_cnt_r + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame buffer addressing
   // ---------------------------------------------------------------
   function automatic logic t1_layout(input logic [15:0] mode);
      t1_layout = mode[txb_pkg::MODE_T1_BIT] |
                  mode[txb_pkg::MODE_E1T1SIG_BIT];
   endfunction

   function automatic logic [16:0] buf_addr(
      input logic [2:0] line,
      input logic [2:0] mf,
      input logic [4:0] frame,
      input logic [4:0] chan,
      input logic t1
   );
      logic [16:0] mf_off;
      // E1 mf 0..7 frames 0..15; T1 mf 0..3 frames 0..31
      mf_off = t1 ? (17'(mf[1:0]) << txb_pkg::T1_MF_SHIFT)
                  : (17'(mf) << txb_pkg::E1_MF_SHIFT);
      buf_addr = txb_pkg::TX_BUF_BASE +
                 (17'(line) << txb_pkg::LINE_SHIFT) + mf_off +
                 (17'(t1 ? frame : {1'b0, frame[3:0]})
                    << txb_pkg::FRAME_SHIFT) +
                 17'(chan[4:1]);
   endfunction

   // ---------------------------------------------------------------
   // Lookup operand concatenation and result field select
   // ---------------------------------------------------------------
   always_comb begin
      lk_operand = 13'h0000;
      unique case (lk_hold_r.op)
         txb_pkg::OP_DIV:
            lk_operand = {2'b00, lk_hold_r.arg_a[5:0],
                          lk_hold_r.arg_b[4:0]};
         txb_pkg::OP_MOD_ADD:
            lk_operand = {lk_hold_r.arg_a, lk_hold_r.arg_b};
         txb_pkg::OP_MULT:
            lk_operand = {2'b00, lk_hold_r.arg_a[5:0],
                          lk_hold_r.arg_b[4:0]};
         txb_pkg::OP_T1_MF_DIV,
         txb_pkg::OP_E1_MF_DIV:
            lk_operand = {6'h00, lk_hold_r.arg_a};
         default:
            lk_operand = 13'h0000;
      endcase
   end

   always_comb begin
      lk_result = 8'h00;
      unique case (lk_hold_r.op)
         txb_pkg::OP_DIV:
            lk_result = sram_rdata[txb_pkg::DIV_LSB +: 8];
         txb_pkg::OP_MOD_ADD:
            if (line_mode_r[lk_hold_r.line][txb_pkg::MODE_T1_BIT] &&
                line_mode_r[lk_hold_r.line][txb_pkg::MODE_STRUCT_BIT])
            begin
               lk_result = {1'b0,
                  sram_rdata[txb_pkg::MOD120_LSB +: 7]};
            end else begin
               lk_result = {1'b0,
                  sram_rdata[txb_pkg::MOD128_LSB +: 7]};
            end
         txb_pkg::OP_MULT:
            lk_result = sram_rdata[txb_pkg::MULT_LSB +: 8];
         txb_pkg::OP_T1_MF_DIV:
            lk_result = sram_rdata[txb_pkg::T1_MF_LSB +: 8];
         txb_pkg::OP_E1_MF_DIV:
            lk_result = sram_rdata[txb_pkg::E1_MF_LSB +: 8];
         default:
            lk_result = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // SRAM port: byte writes first, lookups fill idle cycles
   // ---------------------------------------------------------------
   // Byte writes never stall, so arrival order is kept by construction.
   always_comb begin
      sram_nxt = '0;
      if (byte_in.valid) begin
         sram_nxt.valid = 1'b1;
         sram_nxt.we = 1'b1;
         sram_nxt.addr = buf_addr(byte_in.line, byte_in.mf,
            byte_in.frame, byte_in.chan,
            t1_layout(line_mode_r[byte_in.line]));
         sram_nxt.be = byte_in.chan[0] ? 2'b10 : 2'b01;
         sram_nxt.wdata = {byte_in.data, byte_in.data};
      end else if (lk_state_r == LK_PEND) begin
         sram_nxt.valid = 1'b1;
         sram_nxt.we = 1'b0;
         sram_nxt.be = 2'b11;
         // One table image for every mode: no mode bit in address
         sram_nxt.addr = txb_pkg::MATH_BASE +
                         17'(lk_operand);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sram_r <= '0;
      end else begin
         sram_r <= sram_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Lookup sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_state_r <= LK_IDLE;
         lk_hold_r <= '0;
         lk_ready_r <= 1'b0;
         lk_rsp_r <= '0;
      end else begin
         lk_rsp_r.valid <= 1'b0;
         unique case (lk_state_r)
            LK_IDLE: begin
               lk_ready_r <= 1'b1;
               if (lk_req.valid && lk_ready_r) begin
                  lk_hold_r <= lk_req;
                  lk_ready_r <= 1'b0;
                  if (hs_mode_r) begin
                     // Table is not loaded in this mode: no read
                     lk_rsp_r <= '{valid: 1'b1, word: 16'h0000,
                                  result: 8'h00};
                  end else begin
                     lk_state_r <= LK_PEND;
                  end
               end
            end
            LK_PEND: begin
               if (!byte_in.valid) begin
                  lk_state_r <= LK_SENT;
               end
            end
            // Read stands on the SRAM port; its data comes a cycle later
            LK_SENT: begin
               lk_state_r <= LK_WAIT;
            end
            LK_WAIT: begin
               lk_rsp_r.valid <= 1'b1;
               lk_rsp_r.word <= sram_rdata;
               lk_rsp_r.result <= lk_result;
               lk_state_r <= LK_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_suppress_blocks: assert property (@(posedge pclk)
      disable iff (!presetn)
      sched_in.valid && suppress_r[sched_in.queue] |=> !build_r.valid)
      else $error("cell built for suppressed queue");

   a_sched_advances: assert property (@(posedge pclk)
      disable iff (!presetn)
      sched_in.valid |=> service_tick_r &&
         build_r.queue == $past(sched_in.queue))
      else $error("service time not scheduled");

   a_write_order: assert property (@(posedge pclk)
      disable iff (!presetn)
      byte_in.valid |=> sram_r.valid && sram_r.we &&
         sram_r.wdata[7:0] == $past(byte_in.data))
      else $error("line byte not written next cycle");

   a_line_window: assert property (@(posedge pclk)
      disable iff (!presetn)
      sram_r.valid && sram_r.we |->
         sram_r.addr[16:14] == 3'h1 &&
         sram_r.addr[13:11] == $past(byte_in.line))
      else $error("byte outside its line buffer");

   a_e1_offset: assert property (@(posedge pclk)
      disable iff (!presetn)
      byte_in.valid && !t1_layout(line_mode_r[byte_in.line]) |=>
         sram_r.addr == 17'h04000 + 17'($past(byte_in.line)) * 2048 +
            17'($past(byte_in.mf)) * 256 +
            17'($past(byte_in.frame[3:0])) * 16 +
            17'($past(byte_in.chan) / 2))
      else $error("E1 buffer offset wrong");

   a_t1_offset: assert property (@(posedge pclk)
      disable iff (!presetn)
      byte_in.valid && t1_layout(line_mode_r[byte_in.line]) |=>
         sram_r.addr == 17'h04000 + 17'($past(byte_in.line)) * 2048 +
            17'($past(byte_in.mf[1:0])) * 512 +
            17'($past(byte_in.frame)) * 16 +
            17'($past(byte_in.chan) / 2))
      else $error("T1 buffer offset wrong");

   a_byte_lane: assert property (@(posedge pclk)
      disable iff (!presetn)
      byte_in.valid |=>
         sram_r.be == ($past(byte_in.chan[0]) ? 2'b10 : 2'b01))
      else $error("byte lane does not match channel parity");

   a_lookup_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      lk_req.valid && lk_ready_r && !hs_mode_r |->
         ##[1:40] (sram_r.valid && !sram_r.we &&
         sram_r.addr[16:13] == 4'h6) ##2 lk_rsp_r.valid)
      else $error("lookup read not issued or answered");

   a_hs_no_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      lk_req.valid && lk_ready_r && hs_mode_r |=>
         lk_rsp_r.valid ##1 (lk_state_r == LK_IDLE && !sram_r.valid ||
         sram_r.we))
      else $error("table read in high-speed unstructured mode");

endmodule

// [testbench/txb_sram_model.sv]
// Purpose: Behavioural external SRAM behind the buffer and lookup block.
// Assumes: Word addressed; read data one cycle after a read request.
// Notes:   Between reads the data bus toggles so stale data never matches.
`timescale 1ns/1ps

module txb_sram_model (
   input wire logic clk,
   input wire txb_pkg::txb_sram_req_t req,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:131071];

   // Whole memory, reserved buffer included, is cleared once at setup
   initial begin
      for (int i = 0; i < 131072; i++) begin
         mem[i] = 16'h0000;
      end
      rdata = 16'h0000;
   end

   // Host loads lookup table words after power-up
   task automatic load(input logic [16:0] a, input logic [15:0] d);
      mem[a] = d;
   endtask

   always @(posedge clk) begin
      if (req.valid && !req.we) begin
         rdata <= mem[req.addr];
      end else begin
         rdata <= ~rdata;
      end
      if (req.valid && req.we && req.be[1]) begin
         mem[req.addr][15:8] <= req.wdata[15:8];
      end
      if (req.valid && req.we && req.be[0]) begin
         mem[req.addr][7:0] <= req.wdata[7:0];
      end
   end
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for the buffer writer and lookup block.
// Assumes: Single 100 MHz clock; SRAM model answers reads next cycle.
// Notes:   Expected addresses and fields are worked out by hand here.
`timescale 1ns/1ps

module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   txb_pkg::txb_sched_t sched_in = '0;
   logic service_tick;
   txb_pkg::txb_sched_t build_out;
   txb_pkg::txb_byte_t byte_in = '0;
   txb_pkg::txb_lk_req_t lk_req = '0;
   logic lk_ready;
   txb_pkg::txb_lk_rsp_t lk_rsp;
   txb_pkg::txb_sram_req_t sram_req;
   logic [15:0] sram_rdata;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic err;

   always #5 pclk = ~pclk;

   txb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sched_in(sched_in), .service_tick(service_tick),
      .build_out(build_out), .byte_in(byte_in), .lk_req(lk_req),
      .lk_ready(lk_ready), .lk_rsp(lk_rsp), .sram_req(sram_req),
      .sram_rdata(sram_rdata));

   txb_sram_model i_sram (.clk(pclk), .req(sram_req), .rdata(sram_rdata));

   task automatic chk(input logic [39:0] got, input logic [39:0] exp,
         input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, 12'h03C, 32'h0);
      chk(rd, {16'h0000, txb_pkg::LINE_MODE_RST}, "mode reset");
      apb(1'b1, 12'h024, 32'hFFFF_5A5A);
      apb(1'b0, 12'h024, 32'h0);
      chk(rd, 32'h0000_5A5A, "mode readback");
      apb(1'b1, 12'h010, 32'h0000_FFFF);
      chk(err, 1'b1, "unmapped write");
      apb(1'b0, 12'h402, 32'h0);
      chk({err, rd}, {1'b1, 32'h0}, "misaligned read");
      apb(1'b1, 12'h004, 32'h0000_1234);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0, "count is read only");
   endtask

   task automatic t_suppress();
      apb(1'b1, 12'h414, 32'h0000_FFFF);
      apb(1'b0, 12'h414, 32'h0);
      chk(rd, 32'h0000_8000, "suppress word");
      @(posedge pclk);
      sched_in <= {1'b1, 8'h05};
      @(posedge pclk);
      sched_in <= {1'b1, 8'h06};
      #1;
      chk(service_tick, 1'b1, "tick suppressed q");
      chk(build_out.valid, 1'b0, "build suppressed q");
      @(posedge pclk);
      sched_in <= '0;
      #1;
      chk(service_tick, 1'b1, "tick open q");
      chk(build_out, {1'b1, 8'h06}, "build open q");
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h1, "built count");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h1, "skipped count");
   endtask

   // Bytes go back to back; each write must appear the cycle after
   task automatic t_bytes();
      txb_pkg::txb_byte_t b [4];
      logic [16:0] ea [4];
      txb_pkg::txb_sram_req_t e;
      b = '{{1'b1, 3'h2, 3'h3, 5'h0F, 5'h1F, 8'hA7},
            {1'b1, 3'h2, 3'h3, 5'h0F, 5'h1E, 8'h5C},
            {1'b1, 3'h3, 3'h3, 5'h17, 5'h10, 8'h3C},
            {1'b1, 3'h4, 3'h2, 5'h11, 5'h01, 8'h81}};
      ea = '{17'h053FF, 17'h053FF, 17'h05F78, 17'h06510};
      apb(1'b1, 12'h02C, 32'h0000_0001);
      apb(1'b1, 12'h030, 32'h0000_1000);
      for (int i = 0; i <= 4; i++) begin
         @(posedge pclk);
         byte_in <= (i < 4) ? b[i] : '0;
         if (i > 0) begin
            #1;
            e = {1'b1, 1'b1, b[i-1].chan[0] ? 2'b10 : 2'b01, ea[i-1],
                 b[i-1].data, b[i-1].data};
            chk(sram_req, e, "byte write");
         end
      end
   endtask

   task automatic lookup(input txb_pkg::txb_op_t op, input logic [2:0] ln,
         input logic [6:0] a, input logic [5:0] b, input logic [16:0] ea,
         input logic [7:0] er, input logic hs);
      logic [16:0] ra;
      logic seen;
      ra = 17'h0;
      seen = 1'b0;
      i_sram.load(ea, 16'hC3A5);
      do begin
         @(posedge pclk);
      end while (lk_ready !== 1'b1);
      lk_req <= {1'b1, op, ln, a, b};
      @(posedge pclk);
      lk_req <= '0;
      for (int n = 0; n < 12; n++) begin
         #1;
         if (sram_req.valid === 1'b1 && sram_req.we === 1'b0) begin
            seen = 1'b1;
            ra = sram_req.addr;
         end
         if (lk_rsp.valid === 1'b1) break;
         @(posedge pclk);
      end
      chk(lk_rsp.valid, 1'b1, "lookup answer");
      chk({seen, ra}, hs ? 18'h0 : {1'b1, ea}, "lookup read");
      chk(lk_rsp.word, hs ? 16'h0 : 16'hC3A5, "lookup word");
      chk(lk_rsp.result, er, "lookup result");
   endtask

   task automatic t_lookups();
      apb(1'b1, 12'h034, 32'h0000_0003);
      lookup(txb_pkg::OP_DIV, 3'h0, 7'h6A, 6'h33, 17'h0C553, 8'hA5,
             1'b0);
      lookup(txb_pkg::OP_MOD_ADD, 3'h2, 7'h7F, 6'h3F, 17'h0DFFF, 8'h25,
             1'b0);
      lookup(txb_pkg::OP_MOD_ADD, 3'h5, 7'h01, 6'h02, 17'h0C042, 8'h43,
             1'b0);
      lookup(txb_pkg::OP_MULT, 3'h0, 7'h55, 6'h2B, 17'h0C2AB, 8'hC3,
             1'b0);
      lookup(txb_pkg::OP_T1_MF_DIV, 3'h0, 7'h5F, 6'h00, 17'h0C05F, 8'hA5,
             1'b0);
      lookup(txb_pkg::OP_E1_MF_DIV, 3'h0, 7'h5F, 6'h00, 17'h0C05F, 8'hC3,
             1'b0);
      apb(1'b1, 12'h000, 32'h0000_0001);
      lookup(txb_pkg::OP_DIV, 3'h0, 7'h01, 6'h01, 17'h0C021, 8'h00,
             1'b1);
      apb(1'b1, 12'h000, 32'h0);
   endtask

   // Whole run is well under 2000 cycles; the limit leaves ample margin
   initial begin
      #200000;
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_suppress();
      t_bytes();
      t_lookups();
      final_report();
   end
endmodule
